// file: src/fns_config_regs.sv
// fns_config_regs: write-only configuration bank of a fractional-N synthesizer
// with its interpolator and reference path. Assumes a serial front end hands
// in whole 32-bit words with a one-cycle strobe on this clock; reference_input
// is an asynchronous pin.
// Operation
// R1 - host keeps fractional word below the modulus word
// R2 - output mux select comes from bits 30..27 of fraction word
// R3 - control code 001 writes the phase word
// R4 - control code 010 writes the modulus/reference word
// R5 - control code 011 writes the function word
// R6 - host keeps phase word below the modulus word
// R7 - phase offset step is 360 degrees over modulus; code saturates it at 4095 millidegrees for moduli below 88
// R8 - host should write phase one when phase features unused
// R9 - noise mode taken from bits 30..29 of modulus word
// R10 - lowest spur mode enables interpolator dither
// R11 - lowest noise mode disables dither, charge pump low-noise region
// R12 - slip reduction enable bit turns on cycle slip reduction
// R13 - charge pump current code from bits 27..24
// R14 - host picks 8/9 prescaler above 3 GHz
// R15 - host keeps division at least 23 or 75 per prescaler
// R16 - halver bit inserts divide-by-two after reference counter
// R17 - doubler bit doubles reference before the counter
// R18 - without doubler falling edge only, with doubler both edges
// R19 - reference counter divides by 1 through 32
// R20 - modulus field sets interpolator modulus
// R21 - counter reset bit holds all counters in reset
// R22 - control code 000 writes the fraction/integer word
// R23 - buffered settings apply only after a fraction word write
// R24 - control code 100 writes the clock divider word
// R25 - host writes zero into reserved bits
// R26 - interpolator adds fraction modulo modulus, carry adds one to divide
`timescale 1ns/1ns
module fns_config_regs
	import fns_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic word_valid,
	input wire logic [31:0] word_data,
	input wire logic reference_input,
	output logic [3:0] output_mux_select,
	output logic [11:0] integer_word,
	output logic [11:0] fractional_word,
	output logic [11:0] modulus_word,
	output logic [11:0] phase_word,
	output logic [1:0] noise_mode,
	output logic dither_enable,
	output logic cp_low_noise,
	output logic slip_reduction_enable,
	output logic [3:0] cp_current,
	output logic prescaler_high,
	output logic counter_reset,
	output logic [11:0] clock_div_value,
	output logic [1:0] clock_div_mode,
	output logic [11:0] phase_step_mdeg,
	output logic pfd_ref_pulse,
	output logic [12:0] divide_value,
	output logic [11:0] interp_acc
);
	fns_dbuf_type pend_q;
	fns_dbuf_type live_q;
	logic ref_s1_q;
	logic ref_s2_q;
	logic [2:0] sel_w;
	logic wr_fi_w;
	logic [12:0] acc_sum_w;
	logic carry_w;
	logic [11:0] acc_next_w;
	logic [11:0] step_w;
	logic [11:0] dither_q;
	logic [11:0] mod_safe_w;
	logic [23:0] step_calc_w;

	assign sel_w = word_data[FNS_CTRL_LSB +: FNS_CTRL_W];
	assign wr_fi_w = word_valid && (sel_w == FNS_SEL_FRACTIONAL_WORD_INT); // R22

	// reference pin synchroniser
	always_ff @(posedge clock) begin
		if (reset) begin
			ref_s1_q <= 1'b0;
			ref_s2_q <= 1'b0;
		end else begin
			ref_s1_q <= reference_input;
			ref_s2_q <= ref_s1_q;
		end
	end

	// fraction/integer word, also the load point of the buffered settings
	always_ff @(posedge clock) begin
		if (reset) begin
			output_mux_select <= 4'h0;
			integer_word <= FNS_INT_RST;
			fractional_word <= 12'h000;
		end else if (wr_fi_w) begin
			output_mux_select <= word_data[FNS_MUX_LSB +: 4]; // R2
			integer_word <= word_data[FNS_INT_LSB +: 12];
			fractional_word <= word_data[FNS_FRACTIONAL_WORD_LSB +: 12]; // R1
		end
	end

	// first stage of the buffered settings
	always_ff @(posedge clock) begin
		if (reset) begin
			pend_q.modulus_word <= FNS_MOD_RST;
			pend_q.phase_word <= FNS_PHASE_RST;
			pend_q.ref_count <= FNS_RCNT_RST;
			pend_q.doubler_enable <= 1'b0;
			pend_q.reference_halver_enable <= 1'b0;
			pend_q.cp_current <= FNS_CP_RST;
		end else if (word_valid && sel_w == FNS_SEL_PHASE) begin
			pend_q.phase_word <= word_data[FNS_PHASE_LSB +: 12]; // R3 R6 R8
		end else if (word_valid && sel_w == FNS_SEL_MOD_REF) begin
			pend_q.modulus_word <= word_data[FNS_MOD_LSB +: 12]; // R4 R20
			pend_q.ref_count <= word_data[FNS_RCNT_LSB +: 5]; // R19
			pend_q.doubler_enable <= word_data[FNS_DBL_BIT]; // R17
			pend_q.reference_halver_enable <= word_data[FNS_HALF_BIT]; // R16
			pend_q.cp_current <= word_data[FNS_CP_LSB +: 4]; // R13
		end
	end

	// second stage: a fraction word write makes pending settings live
	always_ff @(posedge clock) begin
		if (reset) begin
			live_q.modulus_word <= FNS_MOD_RST;
			live_q.phase_word <= FNS_PHASE_RST;
			live_q.ref_count <= FNS_RCNT_RST;
			live_q.doubler_enable <= 1'b0;
			live_q.reference_halver_enable <= 1'b0;
			live_q.cp_current <= FNS_CP_RST;
		end else if (wr_fi_w) begin
			live_q <= pend_q; // R23
		end
	end

	// unbuffered fields of the modulus/reference word
	always_ff @(posedge clock) begin
		if (reset) begin
			noise_mode <= FNS_NOISE_LOWEST;
			slip_reduction_enable <= 1'b0;
			prescaler_high <= 1'b0;
		end else if (word_valid && sel_w == FNS_SEL_MOD_REF) begin
			noise_mode <= word_data[FNS_NOISE_LSB +: 2]; // R9
			slip_reduction_enable <= word_data[FNS_CSR_BIT]; // R12
			prescaler_high <= word_data[FNS_PRESC_BIT]; // R14 R15
		end
	end

	// dither and charge pump region follow the noise mode
	always_ff @(posedge clock) begin
		if (reset) begin
			dither_enable <= 1'b0;
			cp_low_noise <= 1'b1;
		end else begin
			dither_enable <= (noise_mode == FNS_NOISE_LOWSPUR); // R10
			cp_low_noise <= (noise_mode == FNS_NOISE_LOWEST); // R11
		end
	end

	// function word: counter reset bit only; others are not modelled
	always_ff @(posedge clock) begin
		if (reset)
			counter_reset <= 1'b0;
		else if (word_valid && sel_w == FNS_SEL_FUNCTION)
			counter_reset <= word_data[FNS_CRST_BIT]; // R5 R21
	end

	// clock divider word is stored for the resync timer outside
	always_ff @(posedge clock) begin
		if (reset) begin
			clock_div_value <= 12'h000;
			clock_div_mode <= 2'h0;
		end else if (word_valid && sel_w == FNS_SEL_CLK_DIV) begin
			clock_div_value <= word_data[FNS_CDIV_LSB +: 12]; // R24
			clock_div_mode <= word_data[FNS_CDMODE_LSB +: 2]; // R24
		end
	end

	// live copies driven out from flops
	always_ff @(posedge clock) begin
		if (reset) begin
			modulus_word <= FNS_MOD_RST;
			phase_word <= FNS_PHASE_RST;
			cp_current <= FNS_CP_RST;
		end else begin
			modulus_word <= live_q.modulus_word; // R20
			phase_word <= live_q.phase_word;
			cp_current <= live_q.cp_current; // R13
		end
	end

	// phase step in millidegrees; a zero modulus is treated as one
	assign mod_safe_w = (live_q.modulus_word == 12'h000) ? 12'h001
		: live_q.modulus_word;
	assign step_calc_w = 24'h057E40 / {12'h000, mod_safe_w}; // R7

	always_ff @(posedge clock) begin
		if (reset)
			phase_step_mdeg <= 12'h000;
		else
			phase_step_mdeg <= (step_calc_w > 24'h000FFF) ? 12'hFFF
				: step_calc_w[11:0]; // R7
	end

	fns_ref_path u_ref (
		.clock(clock),
		.reset(reset),
		.hold(counter_reset),
		.ref_sync(ref_s2_q),
		.doubler_enable(live_q.doubler_enable),
		.reference_halver_enable(live_q.reference_halver_enable),
		.ref_count(live_q.ref_count),
		.pfd_ref_pulse(pfd_ref_pulse)
	);

	// interpolator; dither adds a small lfsr bit to the step, the limited
	// randomisation trades spectral purity for area
	always_ff @(posedge clock) begin
		if (reset)
			dither_q <= 12'hACE;
		else if (pfd_ref_pulse)
			dither_q <= {dither_q[10:0],
				dither_q[11] ^ dither_q[10] ^ dither_q[9] ^ dither_q[3]};
	end

	assign step_w = fractional_word; // R1
	assign acc_sum_w = {1'b0, interp_acc} + {1'b0, step_w}
		+ {12'h000, dither_enable & dither_q[0]}; // R10 R11
	assign carry_w = acc_sum_w >= {1'b0, live_q.modulus_word};
	assign acc_next_w = carry_w
		? 12'(acc_sum_w - {1'b0, live_q.modulus_word}) : acc_sum_w[11:0];

	always_ff @(posedge clock) begin
		if (reset || counter_reset) begin
			interp_acc <= 12'h000; // R21
			divide_value <= {1'b0, FNS_INT_RST};
		end else if (wr_fi_w) begin
			// reload seeds the accumulator with the phase word
			interp_acc <= pend_q.phase_word;
			divide_value <= {1'b0, integer_word};
		end else if (pfd_ref_pulse) begin
			interp_acc <= acc_next_w; // R26
			divide_value <= {1'b0, integer_word} + {12'h000, carry_w}; // R26
		end
	end
endmodule

// file: src/fns_pkg.sv
// fns_pkg: field layout, control codes and reset values of the synthesizer
// configuration words. Assumes a 32-bit word arrives with control bits in [2:0].
package fns_pkg;
	localparam int FNS_CTRL_LSB = 0;
	localparam int FNS_CTRL_W = 3;
	localparam logic [2:0] FNS_SEL_FRACTIONAL_WORD_INT = 3'h0;
	localparam logic [2:0] FNS_SEL_PHASE = 3'h1;
	localparam logic [2:0] FNS_SEL_MOD_REF = 3'h2;
	localparam logic [2:0] FNS_SEL_FUNCTION = 3'h3;
	localparam logic [2:0] FNS_SEL_CLK_DIV = 3'h4;
	// fraction/integer word
	localparam int FNS_FRACTIONAL_WORD_LSB = 3;
	localparam int FNS_INT_LSB = 15;
	localparam int FNS_MUX_LSB = 27;
	// phase word
	localparam int FNS_PHASE_LSB = 3;
	// modulus/reference word
	localparam int FNS_MOD_LSB = 3;
	localparam int FNS_RCNT_LSB = 15;
	localparam int FNS_DBL_BIT = 20;
	localparam int FNS_HALF_BIT = 21;
	localparam int FNS_PRESC_BIT = 22;
	localparam int FNS_CP_LSB = 24;
	localparam int FNS_CSR_BIT = 28;
	localparam int FNS_NOISE_LSB = 29;
	// function word
	localparam int FNS_CRST_BIT = 3;
	// clock divider word
	localparam int FNS_CDIV_LSB = 7;
	localparam int FNS_CDMODE_LSB = 19;
	// noise mode codes
	localparam logic [1:0] FNS_NOISE_LOWEST = 2'h0;
	localparam logic [1:0] FNS_NOISE_LOWSPUR = 2'h3;
	// reset values
	localparam logic [11:0] FNS_MOD_RST = 12'h002;
	localparam logic [11:0] FNS_PHASE_RST = 12'h001;
	localparam logic [11:0] FNS_INT_RST = 12'h017;
	localparam logic [4:0] FNS_RCNT_RST = 5'h01;
	localparam logic [3:0] FNS_CP_RST = 4'h0;

	typedef struct packed {
		logic [11:0] modulus_word;
		logic [11:0] phase_word;
		logic [4:0] ref_count;
		logic doubler_enable;
		logic reference_halver_enable;
		logic [3:0] cp_current;
	} fns_dbuf_type;
endpackage

// file: src/fns_ref_path.sv
// fns_ref_path: reference doubler, 5-bit counter and halver feeding the
// phase_freq_detector reference. Assumes reference_input is already synced.
`timescale 1ns/1ns
module fns_ref_path
	import fns_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic hold,
	input wire logic ref_sync,
	input wire logic doubler_enable,
	input wire logic reference_halver_enable,
	input wire logic [4:0] ref_count,
	output logic pfd_ref_pulse
);
	logic ref_prev_q;
	logic [4:0] rcnt_q;
	logic half_q;
	logic edge_w;
	logic rdone_w;

	// doubler takes both edges, otherwise the falling edge only
	assign edge_w = doubler_enable ? (ref_sync ^ ref_prev_q)
		: (ref_prev_q & ~ref_sync); // R17 R18
	// counter code 0 divides by 32, code n by n
	assign rdone_w = edge_w && (rcnt_q == (ref_count - 5'h01)); // R19

	always_ff @(posedge clock) begin
		if (reset)
			ref_prev_q <= 1'b0;
		else
			ref_prev_q <= ref_sync;
	end

	always_ff @(posedge clock) begin
		if (reset || hold) begin
			rcnt_q <= 5'h00;
		end else if (rdone_w) begin
			rcnt_q <= 5'h00;
		end else if (edge_w) begin
			rcnt_q <= rcnt_q + 5'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (reset || hold) begin
			half_q <= 1'b0;
			pfd_ref_pulse <= 1'b0;
		end else begin
			if (rdone_w)
				half_q <= ~half_q; // R16
			pfd_ref_pulse <= rdone_w
				&& (!reference_halver_enable || half_q); // R16
		end
	end
endmodule

// file: dv/fns_host_model.sv
// fns_host_model: host that writes whole configuration words and drives the
// reference pin. Assumes words are taken on the rising clock edge.
`timescale 1ns/1ns
module fns_host_model(
	input wire logic clock,
	output logic word_valid,
	output logic [31:0] word_data,
	output logic reference_input
);
	initial begin
		word_valid = 1'b0;
		word_data = 32'h00000000;
		reference_input = 1'b0;
		// reference runs free, period of eight clocks
		forever begin
			repeat (4) @(negedge clock);
			reference_input = ~reference_input;
		end
	end
	// callers keep reserved bits zero, fields below the modulus
	task automatic send(input logic [31:0] w);
		@(negedge clock);
		word_valid = 1'b1;
		word_data = w;
		@(negedge clock);
		word_valid = 1'b0;
		// stale data is inverted so it never mimics the last word
		word_data = ~w;
	endtask
endmodule

// file: dv/fns_config_regs_chk.sv
// fns_config_regs_chk: timing relations of the configuration bank.
// Assumes it is bound to fns_config_regs and sees only its ports.
`timescale 1ns/1ns
module fns_config_regs_chk
	import fns_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic word_valid,
	input wire logic [31:0] word_data,
	input wire logic [3:0] output_mux_select,
	input wire logic [11:0] integer_word,
	input wire logic [11:0] modulus_word,
	input wire logic [1:0] noise_mode,
	input wire logic dither_enable,
	input wire logic cp_low_noise,
	input wire logic slip_reduction_enable,
	input wire logic counter_reset,
	input wire logic [11:0] clock_div_value,
	input wire logic pfd_ref_pulse,
	input wire logic [11:0] interp_acc
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	logic f0, f2, f3, f4;
	assign f0 = word_valid && word_data[2:0] == FNS_SEL_FRACTIONAL_WORD_INT;
	assign f2 = word_valid && word_data[2:0] == FNS_SEL_MOD_REF;
	assign f3 = word_valid && word_data[2:0] == FNS_SEL_FUNCTION;
	assign f4 = word_valid && word_data[2:0] == FNS_SEL_CLK_DIV;
	mux_load_a: assert property (f0 |=>
		output_mux_select == $past(word_data[30:27])) else $error("mux");
	int_load_a: assert property (f0 |=>
		integer_word == $past(word_data[26:15])) else $error("int");
	noise_load_a: assert property (f2 |=>
		noise_mode == $past(word_data[30:29])) else $error("noise");
	slip_load_a: assert property (f2 |=>
		slip_reduction_enable == $past(word_data[28])) else $error("csr");
	crst_load_a: assert property (f3 |=>
		counter_reset == $past(word_data[3])) else $error("crst");
	cdiv_load_a: assert property (f4 |=>
		clock_div_value == $past(word_data[18:7])) else $error("cdiv");
	dither_on_a: assert property (noise_mode == 2'h3 |=>
		dither_enable) else $error("dither");
	quiet_mode_a: assert property (noise_mode == 2'h0 [*2] |->
		cp_low_noise && !dither_enable) else $error("low noise");
	mod_hold_a: assert property ($changed(modulus_word) |->
		$past(f0, 2)) else $error("modulus early");
	crst_clear_a: assert property (counter_reset [*2] |->
		interp_acc == 12'h000 && !pfd_ref_pulse) else $error("held");
	cover property (f0 ##2 $changed(modulus_word));
	cover property (dither_enable);
	cover property (counter_reset [*2]);
endmodule
bind fns_config_regs fns_config_regs_chk chk(.clock(clock), .reset(reset),
	.word_valid(word_valid), .word_data(word_data),
	.output_mux_select(output_mux_select), .integer_word(integer_word),
	.modulus_word(modulus_word), .noise_mode(noise_mode),
	.dither_enable(dither_enable), .cp_low_noise(cp_low_noise),
	.slip_reduction_enable(slip_reduction_enable),
	.counter_reset(counter_reset), .clock_div_value(clock_div_value),
	.pfd_ref_pulse(pfd_ref_pulse), .interp_acc(interp_acc));

// file: dv/fns_config_regs_bench.sv
// fns_config_regs_bench: scenarios for the configuration bank.
// Assumes fns_host_model drives words and the reference pin.
`timescale 1ns/1ns
module fns_config_regs_bench;
	import fns_pkg::*;
	logic clock, reset, word_valid, reference_input;
	logic [31:0] word_data;
	logic [11:0] integer_word, fractional_word, modulus_word, phase_word;
	logic [11:0] clock_div_value, phase_step_mdeg, interp_acc;
	logic [3:0] output_mux_select, cp_current;
	logic [1:0] noise_mode, clock_div_mode;
	logic dither_enable, cp_low_noise, slip_reduction_enable;
	logic prescaler_high, counter_reset, pfd_ref_pulse;
	logic [12:0] divide_value;
	int errors = 0;
	int checks_done = 0;
	fns_host_model host(.clock(clock), .word_valid(word_valid),
		.word_data(word_data), .reference_input(reference_input));
	fns_config_regs DUT(.clock(clock), .reset(reset),
		.word_valid(word_valid), .word_data(word_data),
		.reference_input(reference_input),
		.output_mux_select(output_mux_select), .integer_word(integer_word),
		.fractional_word(fractional_word), .modulus_word(modulus_word),
		.phase_word(phase_word), .noise_mode(noise_mode),
		.dither_enable(dither_enable), .cp_low_noise(cp_low_noise),
		.slip_reduction_enable(slip_reduction_enable),
		.cp_current(cp_current), .prescaler_high(prescaler_high),
		.counter_reset(counter_reset), .clock_div_value(clock_div_value),
		.clock_div_mode(clock_div_mode), .phase_step_mdeg(phase_step_mdeg),
		.pfd_ref_pulse(pfd_ref_pulse), .divide_value(divide_value),
		.interp_acc(interp_acc));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	task check(input logic [12:0] seen, input logic [12:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task results;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// slip reduction only with halver on and minimum pump current
	function logic [31:0] modw(input logic [1:0] nm, input logic [4:0] rc,
		input logic dbl, input logic half);
		modw = {1'b0, nm, half, half ? 4'h0 : 4'h5, 2'b01, half, dbl, rc,
			12'h064, FNS_SEL_MOD_REF};
	endfunction
	// integer 85 with the 8/9 prescaler keeps division above its floor
	localparam logic [31:0] FRW = {1'b0, 4'hA, 12'h055, 12'h01E, 3'h0};
	// counts clocks up to the next detector pulse, bounded
	task wait_pulse(output int n);
		n = 1;
		@(negedge clock);
		while (pfd_ref_pulse !== 1'b1 && n < 400) begin
			@(negedge clock);
			n++;
		end
		if (n >= 400) begin
			errors++;
			results();
		end
	endtask
	task t_reset;
		check(modulus_word, FNS_MOD_RST);
		check(phase_word, FNS_PHASE_RST);
		check(cp_low_noise, 1'b1);
		check(divide_value, 13'h0017);
	endtask
	task t_buffer;
		host.send(modw(2'h0, 5'h03, 1'b0, 1'b0));
		host.send({17'h0, 12'h001, FNS_SEL_PHASE});
		check(prescaler_high, 1'b1);
		check(modulus_word, FNS_MOD_RST);
		check(cp_current, FNS_CP_RST);
		host.send(FRW);
		check(output_mux_select, 4'hA);
		check(fractional_word, 12'h01E);
		check(integer_word, 12'h055);
		@(negedge clock);
		check(modulus_word, 12'h064);
		check(cp_current, 4'h5);
		check(phase_word, 12'h001);
	endtask
	task t_noise;
		for (int m = 3; m >= 0; m--) begin
			host.send(modw(m[1:0], 5'h03, 1'b0, 1'b0));
			repeat (2) @(negedge clock);
			check(noise_mode, m[1:0]);
			check(dither_enable, m == 3);
			check(cp_low_noise, m == 0);
		end
	endtask
	task t_refused;
		for (int c = 5; c <= 7; c++) begin
			host.send({1'b0, 4'hF, 24'h0, c[2:0]});
			check(output_mux_select, 4'hA);
			check(noise_mode, 2'h0);
		end
	endtask
	task ref_one(input logic dbl, input logic half, input logic [4:0] rc,
		input int gap);
		int n;
		host.send(modw(2'h0, rc, dbl, half));
		host.send(FRW);
		check(slip_reduction_enable, half);
		repeat (3) wait_pulse(n);
		check(13'(n), 13'(gap));
	endtask
	task t_ref;
		ref_one(1'b0, 1'b0, 5'h03, 24);
		ref_one(1'b1, 1'b0, 5'h03, 12);
		ref_one(1'b0, 1'b1, 5'h03, 48);
		ref_one(1'b0, 1'b0, 5'h01, 8);
		ref_one(1'b0, 1'b0, 5'h00, 256);
	endtask
	task t_acc;
		int n;
		host.send(modw(2'h0, 5'h03, 1'b0, 1'b0));
		// align to a pulse so no detector pulse straddles the reload
		wait_pulse(n);
		host.send(FRW);
		for (int k = 1; k <= 4; k++) begin
			wait_pulse(n);
			repeat (2) @(negedge clock);
			check(interp_acc, 13'((1 + 30 * k) % 100));
			check(divide_value, 13'h0055 + 13'(k == 4));
		end
		check(phase_step_mdeg, 12'hE10);
	endtask
	task t_crst;
		int n;
		host.send({28'h0, 1'b1, FNS_SEL_FUNCTION});
		check(counter_reset, 1'b1);
		repeat (40) begin
			@(negedge clock);
			check(pfd_ref_pulse, 1'b0);
		end
		check(interp_acc, 12'h000);
		host.send({28'h0, 1'b0, FNS_SEL_FUNCTION});
		wait_pulse(n);
		check(counter_reset, 1'b0);
	endtask
	task t_cdiv;
		host.send({11'h0, 2'h2, 12'hABC, 4'h0, FNS_SEL_CLK_DIV});
		check(clock_div_value, 12'hABC);
		check(clock_div_mode, 2'h2);
	endtask
	initial begin
		reset = 1'b1;
		repeat (3) @(negedge clock);
		reset = 1'b0;
		t_reset();
		t_buffer();
		t_noise();
		t_refused();
		t_ref();
		t_acc();
		t_crst();
		t_cdiv();
		results();
	end
endmodule
